// ===== rtl/fcp_flash_ctrl.sv
// Flash program and erase controller with Wishbone register access
//
// What this block does
// - Erase sets every byte to ones; programming only clears bits
// - Page erase clears all 64 bytes of the selected two-row page
// - High voltage sets only with one select and the setup steps done
// - High voltage bit drives the charge pump on and off
// - Erase with mass select clears the whole array
// - Program and erase selects are never both one
// - Programming works on aligned 32-byte rows
// - With program or erase select, array writes before high voltage latch the address only
// - High voltage refused when target lies in protected block
// - Protection byte zeros protect all; ones leave all open
// - Non-open protection byte also guards itself unless test voltage
// - Protected start is 11, protection bits, six zeros, to top
// - Wait or stop aborts the operation into standby
// - Array reads held off for the recovery time after high voltage
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module fcp_flash_ctrl
    import fcp_pkg::*;
#(
    parameter int DEPTH = 8192,
    parameter int AW = 13
)(
    input wire logic clk_sys, // System clock, 25 MHz
    input wire logic sys_rst, // Synchronous reset, high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [17:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte enables
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic cpu_low_power_i, // CPU in wait or stop
    input wire logic test_high_voltage_i, // Test voltage on pin
    output logic pump_on_o, // Charge pump and high voltage on
    output logic flash_standby_o // Flash idle, controls inactive
);
    typedef struct packed {
        logic program_select;
        logic erase;
        logic mass;
        logic high_voltage_enable;
        logic prot_read;
        logic latched;
        logic refused;
        logic [15:0] seq_adr;
        fcp_state_t st;
        logic ack;
        logic [31:0] dat;
    } fcp_regs_t;

    fcp_regs_t r_q;
    fcp_regs_t r_d;

    logic [15:0] cpu_adr;
    logic is_ctrl;
    logic is_stat;
    logic is_bpr;
    logic is_arr;
    logic req;
    logic stall;
    logic rcv_busy;
    logic rcv_start;
    logic [7:0] arr_rdat;
    logic [7:0] bpr_dat;
    logic [15:0] prot_start;
    logic prot_open;
    logic prot_block;
    logic [7:0] ctl_w;
    logic [7:0] ctl_rd;
    logic [7:0] stat_rd;
    logic both_sel;
    logic np;
    logic ne;
    logic accept;
    fcp_op_t op;
    logic [AW-1:0] op_idx;
    logic [31:0] rd_word;

    function automatic logic fcp_same_row(input logic [15:0] a,
                                          input logic [15:0] b);
        fcp_same_row = (a >> FCP_ROW_LSB) == (b >> FCP_ROW_LSB);
    endfunction

    fcp_array #(
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_array (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .op(op),
        .op_idx(op_idx),
        .op_dat(wb_dat_i[7:0]),
        .rd_idx(cpu_adr[AW-1:0]),
        .rd_dat(arr_rdat),
        .bpr_dat(bpr_dat)
    );

    fcp_timer #(
        .W(8),
        .COUNT(FCP_RCV_CYC)
    ) u_rcv (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .start(rcv_start),
        .busy(rcv_busy)
    );

    // Bus decode; the control words sit inside the array window
    assign cpu_adr = wb_adr_i[17:2];
    assign is_ctrl = (cpu_adr == FCP_CTRL_IDX);
    assign is_stat = (cpu_adr == FCP_STAT_IDX);
    assign is_bpr = (cpu_adr == FCP_BPR_IDX);
    assign is_arr = (cpu_adr >= FCP_ARRAY_BASE) && !is_ctrl && !is_stat;
    assign req = wb_cyc_i && wb_stb_i && !r_q.ack;
    // Reads wait out recovery instead of returning stale data
    assign stall = is_arr && !wb_we_i && rcv_busy;

    // Protection window
    assign prot_start = {FCP_PROT_HI, bpr_dat, FCP_PROT_LO};
    assign prot_open = (bpr_dat == FCP_BPR_OPEN) || test_high_voltage_i;
    // Start can sit above the protection byte, so guard it by name
    assign prot_block = !prot_open &&
        ((r_q.erase && r_q.mass) || (r_q.seq_adr >= prot_start) ||
         (r_q.seq_adr == FCP_BPR_IDX));

    assign ctl_w = wb_dat_i[7:0];
    assign both_sel = ctl_w[FCP_PGM_BIT] && ctl_w[FCP_ERASE_BIT];
    // A write asking for both selects leaves them as they were
    assign np = both_sel ? r_q.program_select : ctl_w[FCP_PGM_BIT];
    assign ne = both_sel ? r_q.erase : ctl_w[FCP_ERASE_BIT];
    assign accept = !r_q.high_voltage_enable && ctl_w[FCP_HIGH_VOLTAGE_ENABLE_BIT] &&
        (r_q.program_select ^ r_q.erase) && (np == r_q.program_select) && (ne == r_q.erase) &&
        r_q.prot_read && r_q.latched && !prot_block;

    always_comb
    begin
        ctl_rd = '0;
        ctl_rd[FCP_PGM_BIT] = r_q.program_select;
        ctl_rd[FCP_ERASE_BIT] = r_q.erase;
        ctl_rd[FCP_MASS_BIT] = r_q.mass;
        ctl_rd[FCP_HIGH_VOLTAGE_ENABLE_BIT] = r_q.high_voltage_enable;
        stat_rd = '0;
        stat_rd[FCP_ST_HV_BIT] = r_q.high_voltage_enable;
        stat_rd[FCP_ST_RCV_BIT] = rcv_busy;
        stat_rd[FCP_ST_PRD_BIT] = r_q.prot_read;
        stat_rd[FCP_ST_LAT_BIT] = r_q.latched;
        stat_rd[FCP_ST_REF_BIT] = r_q.refused;
        stat_rd[FCP_ST_OPEN_BIT] = prot_open;
        if (is_ctrl)
            rd_word = {24'h000000, ctl_rd};
        else if (is_stat)
            rd_word = {24'h000000, stat_rd};
        else if (is_arr)
            rd_word = {24'h000000, arr_rdat};
        else
            rd_word = '0;
    end

    always_comb
    begin
        r_d = r_q;
        r_d.ack = 1'b0;
        op = FCP_OP_NONE;
        op_idx = r_q.seq_adr[AW-1:0];
        rcv_start = 1'b0;
        if (r_q.st == FCP_RECOVER && !rcv_busy)
            r_d.st = (r_q.program_select || r_q.erase) ? FCP_ARMED : FCP_IDLE;
        if (req && !stall)
        begin
            r_d.ack = 1'b1;
            r_d.dat = rd_word;
            if (!wb_we_i && is_bpr && (r_q.program_select || r_q.erase))
                r_d.prot_read = 1'b1;
            if (wb_we_i && wb_sel_i[0])
            begin
                if (is_ctrl)
                begin
                    // Dropping erase under high voltage ends the erase
                    if (r_q.high_voltage_enable && r_q.erase && !ne)
                        op = r_q.mass ? FCP_OP_MASS : FCP_OP_PAGE;
                    r_d.program_select = np;
                    r_d.erase = ne;
                    r_d.mass = ctl_w[FCP_MASS_BIT];
                    if (!r_q.program_select && !r_q.erase && (np || ne))
                    begin
                        r_d.prot_read = 1'b0;
                        r_d.latched = 1'b0;
                        // Recovery may end in this same cycle
                        if (r_d.st == FCP_IDLE)
                            r_d.st = FCP_ARMED;
                    end
                    if (!np && !ne && r_d.st == FCP_ARMED)
                        r_d.st = FCP_IDLE;
                    if (accept)
                    begin
                        r_d.high_voltage_enable = 1'b1;
                        r_d.st = FCP_HV;
                        r_d.refused = 1'b0;
                    end
                    else if (ctl_w[FCP_HIGH_VOLTAGE_ENABLE_BIT] && !r_q.high_voltage_enable)
                        r_d.refused = 1'b1;
                    else if (!ctl_w[FCP_HIGH_VOLTAGE_ENABLE_BIT] && r_q.high_voltage_enable)
                    begin
                        r_d.high_voltage_enable = 1'b0;
                        r_d.st = FCP_RECOVER;
                        rcv_start = 1'b1;
                    end
                end
                else if (is_arr && (r_q.program_select || r_q.erase))
                begin
                    if (!r_q.high_voltage_enable)
                    begin
                        r_d.seq_adr = cpu_adr;
                        r_d.latched = 1'b1;
                    end
                    else if (r_q.program_select && fcp_same_row(cpu_adr, r_q.seq_adr))
                    begin
                        op = FCP_OP_PROG;
                        op_idx = cpu_adr[AW-1:0];
                    end
                end
            end
        end
        // Low power wins over any bus action in the same cycle
        if (cpu_low_power_i)
        begin
            r_d.program_select = 1'b0;
            r_d.erase = 1'b0;
            r_d.mass = 1'b0;
            r_d.high_voltage_enable = 1'b0;
            r_d.prot_read = 1'b0;
            r_d.latched = 1'b0;
            op = FCP_OP_NONE;
            if (r_q.high_voltage_enable)
            begin
                r_d.st = FCP_RECOVER;
                rcv_start = 1'b1;
            end
            else if (r_d.st != FCP_RECOVER)
                r_d.st = FCP_IDLE;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r_q <= '0;
            r_q.st <= FCP_IDLE;
        end
        else
            r_q <= r_d;
    end

    assign wb_ack_o = r_q.ack;
    assign wb_dat_o = r_q.dat;
    assign pump_on_o = r_q.high_voltage_enable;
    assign flash_standby_o = (r_q.st == FCP_IDLE);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    a_sel_exclusive: assert property (!(r_q.program_select && r_q.erase))
        else $error("program and erase selects both set");

    a_high_voltage_enable_setup: assert property ($rose(r_q.high_voltage_enable) |->
        $past(r_q.prot_read && r_q.latched && (r_q.program_select ^ r_q.erase)))
        else $error("high voltage set without setup");

    a_high_voltage_enable_protect: assert property ($rose(r_q.high_voltage_enable) |->
        $past(!prot_block))
        else $error("high voltage set on protected range");

    a_mass_guard: assert property ((op == FCP_OP_MASS) |->
        (bpr_dat == FCP_BPR_OPEN || test_high_voltage_i))
        else $error("mass erase with protection active");

    a_row_program: assert property ((op == FCP_OP_PROG) |->
        ((op_idx >> FCP_ROW_LSB) ==
         (r_q.seq_adr[AW-1:0] >> FCP_ROW_LSB)) &&
        r_q.program_select && r_q.high_voltage_enable)
        else $error("program outside latched row");

    a_idle_write: assert property ((req && wb_we_i && is_arr &&
        !r_q.program_select && !r_q.erase) |-> op == FCP_OP_NONE)
        else $error("array changed with no select");

    a_idle_latch: assert property ((req && wb_we_i && is_arr &&
        !r_q.program_select && !r_q.erase) |=> $stable(r_q.seq_adr))
        else $error("address latched with no select");

    a_lowpower_stop: assert property (cpu_low_power_i |=>
        !r_q.program_select && !r_q.erase && !r_q.high_voltage_enable && !pump_on_o)
        else $error("operation not abandoned in low power");

    a_lowpower_op: assert property (cpu_low_power_i |->
        op == FCP_OP_NONE)
        else $error("array operation during low power");

    a_standby_quiet: assert property (flash_standby_o |->
        !r_q.program_select && !r_q.erase && !r_q.high_voltage_enable)
        else $error("standby with controls active");

    a_recover_hold: assert property ($fell(r_q.high_voltage_enable) |->
        rcv_busy ##0 (r_q.st == FCP_RECOVER)[*8])
        else $error("recovery time cut short");

    a_recover_read: assert property ((req && is_arr && !wb_we_i &&
        rcv_busy) |=> !wb_ack_o)
        else $error("array read answered during recovery");

    a_refuse_flag: assert property ((req && wb_we_i && is_ctrl &&
        wb_sel_i[0] && ctl_w[FCP_HIGH_VOLTAGE_ENABLE_BIT] && !r_q.high_voltage_enable && prot_block &&
        !cpu_low_power_i) |=> r_q.refused && !r_q.high_voltage_enable)
        else $error("protected high voltage request not refused");

    a_both_keep: assert property ((req && wb_we_i && is_ctrl &&
        wb_sel_i[0] && both_sel && !cpu_low_power_i) |=>
        (r_q.program_select == $past(r_q.program_select)) && (r_q.erase == $past(r_q.erase)))
        else $error("write with both selects changed them");

    a_erase_hv: assert property ((op == FCP_OP_PAGE ||
        op == FCP_OP_MASS) |-> r_q.erase && r_q.high_voltage_enable)
        else $error("erase without high voltage");

    a_pump_state: assert property (pump_on_o |-> r_q.st == FCP_HV)
        else $error("pump on outside high voltage state");

    c_page_erase: cover property (op == FCP_OP_PAGE);
    c_mass_erase: cover property (op == FCP_OP_MASS);
    c_row_program: cover property (op == FCP_OP_PROG);
    c_abort_hv: cover property (r_q.high_voltage_enable && cpu_low_power_i);
    c_recover_stall: cover property (req && stall);
endmodule
`default_nettype wire

// ===== rtl/fcp_pkg.sv
// Shared constants and types for the flash program and erase controller
package fcp_pkg;

    // Word indices on the bus; byte address is four times the index
    localparam logic [15:0] FCP_CTRL_IDX = 16'hfe08;
    localparam logic [15:0] FCP_STAT_IDX = 16'hfe09;
    localparam logic [15:0] FCP_BPR_IDX = 16'hff7e;
    localparam logic [15:0] FCP_ARRAY_BASE = 16'he000;

    // Control register bit positions
    localparam int FCP_PGM_BIT = 0;
    localparam int FCP_ERASE_BIT = 1;
    localparam int FCP_MASS_BIT = 2;
    localparam int FCP_HIGH_VOLTAGE_ENABLE_BIT = 3;

    // Status register bit positions
    localparam int FCP_ST_HV_BIT = 0;
    localparam int FCP_ST_RCV_BIT = 1;
    localparam int FCP_ST_PRD_BIT = 2;
    localparam int FCP_ST_LAT_BIT = 3;
    localparam int FCP_ST_REF_BIT = 4;
    localparam int FCP_ST_OPEN_BIT = 5;

    // Array geometry
    localparam int FCP_PAGE_LSB = 6;
    localparam int FCP_ROW_LSB = 5;
    localparam logic [7:0] FCP_BYTE_ERASED = 8'hff;
    localparam logic [7:0] FCP_BPR_OPEN = 8'hff;
    localparam logic [1:0] FCP_PROT_HI = 2'h3;
    localparam logic [5:0] FCP_PROT_LO = 6'h00;

    // Recovery time after high voltage is removed
    localparam int FCP_CLK_PERIOD_NS = 40;
    localparam int FCP_RCV_NS = 1000;
    localparam int FCP_RCV_CYC =
        (FCP_RCV_NS + FCP_CLK_PERIOD_NS - 1) / FCP_CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        FCP_IDLE,
        FCP_ARMED,
        FCP_HV,
        FCP_RECOVER
    } fcp_state_t;

    typedef enum logic [1:0] {
        FCP_OP_NONE,
        FCP_OP_PROG,
        FCP_OP_PAGE,
        FCP_OP_MASS
    } fcp_op_t;

endpackage

// ===== rtl/fcp_timer.sv
// Recovery delay counter
`timescale 1ns/1ps
`default_nettype none
module fcp_timer
    import fcp_pkg::*;
#(
    parameter int W = 8,
    parameter int COUNT = FCP_RCV_CYC
)(
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic start, // Load pulse
    output logic busy // High while counting
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } fcp_tmr_t;

    fcp_tmr_t r_q;
    fcp_tmr_t r_d;

    always_comb
    begin
        r_d = r_q;
        if (start)
            r_d.cnt = W'(COUNT);
        else if (r_q.cnt != '0)
            r_d.cnt = r_q.cnt - 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            r_q <= '0;
        else
            r_q <= r_d;
    end

    assign busy = (r_q.cnt != '0);
endmodule
`default_nettype wire

// ===== rtl/fcp_array.sv
// Byte-wide flash array storage with program and erase operations
`timescale 1ns/1ps
`default_nettype none
module fcp_array
    import fcp_pkg::*;
#(
    parameter int DEPTH = 8192,
    parameter int AW = 13
)(
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire fcp_op_t op, // Operation this cycle
    input wire logic [AW-1:0] op_idx, // Target byte or page
    input wire logic [7:0] op_dat, // Program data
    input wire logic [AW-1:0] rd_idx, // Read index
    output logic [7:0] rd_dat, // Read data
    output logic [7:0] bpr_dat // Protection byte
);
    logic [7:0] mem [DEPTH];

    // Model only: storage comes up blank rather than keeping contents
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= FCP_BYTE_ERASED;
        end
        else
        begin
            case (op)
                // Programming can only pull bits to zero
                FCP_OP_PROG: mem[op_idx] <= mem[op_idx] & op_dat;
                FCP_OP_PAGE:
                begin
                    for (int i = 0; i < DEPTH; i++)
                        if ((AW'(i) >> FCP_PAGE_LSB) ==
                            (op_idx >> FCP_PAGE_LSB))
                            mem[i] <= FCP_BYTE_ERASED;
                end
                FCP_OP_MASS:
                begin
                    for (int i = 0; i < DEPTH; i++)
                        mem[i] <= FCP_BYTE_ERASED;
                end
                default: ;
            endcase
        end
    end

    assign rd_dat = mem[rd_idx];
    assign bpr_dat = mem[FCP_BPR_IDX[AW-1:0]];
endmodule
`default_nettype wire

// ===== dv/fcp_cpu_model.sv
// Software-side bus master model for the flash controller
`timescale 1ns/1ps
`default_nettype none
module fcp_cpu_model (
    input wire logic clk_sys, // System clock
    output logic wb_cyc_o, // Cycle
    output logic wb_stb_o, // Strobe
    output logic wb_we_o, // Write
    output logic [17:0] wb_adr_o, // Byte address
    output logic [3:0] wb_sel_o, // Byte enables
    output logic [31:0] wb_dat_o, // Write data
    input wire logic [31:0] wb_dat_i, // Read data
    input wire logic wb_ack_i // Acknowledge
);
    initial
    begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 18'h00000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
    end

    // Caller code lives in RAM, never in the array
    task automatic xfer(input logic we, input logic [15:0] idx,
        input logic [7:0] d, input logic [3:0] be, output logic [7:0] q,
        output int lat);
        lat = 0;
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= {idx, 2'h0};
        wb_sel_o <= be;
        wb_dat_o <= {24'h000000, d};
        do
        begin
            @(posedge clk_sys);
            lat++;
        end
        while (wb_ack_i !== 1'b1);
        q = wb_dat_i[7:0];
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        // Released data must not look still valid
        wb_dat_o <= ~{24'h000000, d};
        @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

// ===== dv/fcp_flash_ctrl_tb.sv
// Self-checking bench for the flash program and erase controller
`timescale 1ns/1ps
`default_nettype none
module fcp_flash_ctrl_tb;
    import fcp_pkg::*;
    typedef struct packed {
        logic [15:0] idx;
        logic [7:0] d;
        logic [7:0] exp;
    } fcp_row_t;
    localparam fcp_row_t ROWS [9] = '{
        '{FCP_CTRL_IDX, 8'h01, 8'h01},
        '{FCP_CTRL_IDX, 8'h03, 8'h01},
        '{FCP_CTRL_IDX, 8'h00, 8'h00},
        '{FCP_CTRL_IDX, 8'h06, 8'h06},
        '{FCP_CTRL_IDX, 8'h07, 8'h06},
        '{FCP_CTRL_IDX, 8'h00, 8'h00},
        '{FCP_CTRL_IDX, 8'h08, 8'h00},
        '{16'h1000, 8'h5a, 8'h00},
        '{16'he000, 8'h12, 8'hff}
    };
    logic clk_sys, sys_rst, cyc, stb, we, ack, low_pwr, tst_hv, pump, stby;
    logic [17:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [7:0] q;
    int lat;
    int bad_count;
    int tests_run;

    fcp_flash_ctrl #(.DEPTH(8192), .AW(13)) i_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .cpu_low_power_i(low_pwr), .test_high_voltage_i(tst_hv),
        .pump_on_o(pump), .flash_standby_o(stby));
    fcp_cpu_model i_cpu (
        .clk_sys(clk_sys), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
        .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat),
        .wb_dat_i(rdat), .wb_ack_i(ack));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        i_cpu.xfer(1'b1, idx, d, 4'h1, q, lat);
    endtask

    task automatic rd(input logic [15:0] idx);
        i_cpu.xfer(1'b0, idx, 8'h00, 4'h1, q, lat);
    endtask

    // Whole software sequence; steps kept in order
    task automatic run_op(input logic [7:0] s, input logic [15:0] idx,
        input logic [7:0] d, input logic hv);
        wr(FCP_CTRL_IDX, s);
        rd(FCP_BPR_IDX);
        wr(idx, d);
        wr(FCP_CTRL_IDX, s | 8'h08);
        chk("pump", {7'h00, hv}, {7'h00, pump});
        chk("standby", 8'h00, {7'h00, stby});
        if (s[0])
        begin
            wr(idx, d);
            wr(idx ^ 16'h0020, 8'h00);
        end
        wr(FCP_CTRL_IDX, {4'h0, hv, s[2], 2'h0});
        wr(FCP_CTRL_IDX, 8'h00);
        chk("pump off", 8'h00, {7'h00, pump});
    endtask

    task automatic expect_byte(input logic [15:0] idx, input logic [7:0] e);
        rd(idx);
        chk("array byte", e, q);
    endtask

    initial
    begin
        sys_rst = 1'b1;
        low_pwr = 1'b0;
        tst_hv = 1'b0;
        bad_count = 0;
        tests_run = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("reset pump", 8'h00, {7'h00, pump});
        chk("reset standby", 8'h01, {7'h00, stby});
        rd(FCP_CTRL_IDX);
        chk("reset control", 8'h00, q);
        $display("test reset done");
        foreach (ROWS[i])
        begin
            wr(ROWS[i].idx, ROWS[i].d);
            rd(ROWS[i].idx);
            chk("table read", ROWS[i].exp, q);
        end
        $display("test table done");
        run_op(8'h01, 16'he000, 8'ha5, 1'b1);
        rd(16'he000);
        chk("recovery", 8'h01, {7'h00, lat >= FCP_RCV_CYC - 1});
        chk("programmed", 8'ha5, q);
        expect_byte(16'he020, 8'hff);
        run_op(8'h01, 16'he040, 8'h00, 1'b1);
        run_op(8'h02, 16'he010, 8'h77, 1'b1);
        expect_byte(16'he000, 8'hff);
        expect_byte(16'he040, 8'h00);
        run_op(8'h06, 16'he000, 8'h00, 1'b1);
        expect_byte(16'he040, 8'hff);
        $display("test program erase done");
        run_op(8'h01, FCP_BPR_IDX, 8'hfe, 1'b1);
        run_op(8'h01, 16'hff80, 8'h00, 1'b0);
        expect_byte(16'hff80, 8'hff);
        rd(FCP_STAT_IDX);
        chk("refused flag", 8'h01, {7'h00, q[FCP_ST_REF_BIT]});
        chk("open flag", 8'h00, {7'h00, q[FCP_ST_OPEN_BIT]});
        run_op(8'h01, 16'hff40, 8'h00, 1'b1);
        expect_byte(16'hff40, 8'h00);
        run_op(8'h01, FCP_BPR_IDX, 8'h00, 1'b0);
        tst_hv <= 1'b1;
        run_op(8'h01, FCP_BPR_IDX, 8'h00, 1'b1);
        tst_hv <= 1'b0;
        run_op(8'h01, 16'he100, 8'h00, 1'b0);
        tst_hv <= 1'b1;
        run_op(8'h06, FCP_BPR_IDX, 8'h00, 1'b1);
        tst_hv <= 1'b0;
        expect_byte(FCP_BPR_IDX, 8'hff);
        expect_byte(16'hff40, 8'hff);
        $display("test protection done");
        wr(FCP_CTRL_IDX, 8'h01);
        rd(FCP_BPR_IDX);
        wr(16'he000, 8'h00);
        wr(FCP_CTRL_IDX, 8'h09);
        low_pwr <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("abort pump", 8'h00, {7'h00, pump});
        low_pwr <= 1'b0;
        wr(16'he000, 8'h00);
        expect_byte(16'he000, 8'hff);
        chk("abort standby", 8'h01, {7'h00, stby});
        $display("test abort done");
        i_cpu.xfer(1'b1, FCP_CTRL_IDX, 8'h01, 4'h0, q, lat);
        rd(FCP_CTRL_IDX);
        chk("masked write", 8'h00, q);
        wr(FCP_CTRL_IDX, 8'h02);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("second reset standby", 8'h01, {7'h00, stby});
        chk("second reset pump", 8'h00, {7'h00, pump});
        rd(FCP_CTRL_IDX);
        chk("second reset control", 8'h00, q);
        $display("test second reset done");
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        $display("unexpected watchdog expected finish seen hang");
        test_done();
    end
endmodule
`default_nettype wire
